// *** hw/fci_map.svh ***
// Constants for the command interpreter: opcodes, counts, field bits, offsets.
// Assumes nothing; definitions only.
`ifndef FCI_MAP_SVH
`define FCI_MAP_SVH
`define FCI_OP_LOW_SCAN_HE   5'h1d
`define FCI_OP_RECAL         8'h07
`define FCI_OP_SENSE_INT     8'h08
`define FCI_OP_SPECIFY       8'h03
`define FCI_OP_SEEK          8'h0f
`define FCI_OP_SENSE_DRV     8'h04
`define FCI_LEN_SCAN         4'h9
`define FCI_LEN_RECAL        4'h2
`define FCI_LEN_SENSE_INT    4'h1
`define FCI_LEN_SPECIFY      4'h3
`define FCI_LEN_SEEK         4'h3
`define FCI_LEN_SENSE_DRV    4'h2
`define FCI_RES_SCAN         4'h7
`define FCI_RES_SENSE_INT    4'h2
`define FCI_RES_SENSE_DRV    4'h1
`define FCI_RES_INVALID      4'h1
`define FCI_BIT_MT           7
`define FCI_BIT_FM           6
`define FCI_BIT_SK           5
`define FCI_BIT_HD           2
`define FCI_BIT_INVALID      7
`define FCI_STEP_CONTIG      8'h01
`define FCI_STEP_ALT         8'h02
`define FCI_SPEC_RATE_MS     1
`define FCI_SPEC_UNLOAD_MS   16
`define FCI_SPEC_LOAD_MS     2
`define FCI_CLK_KHZ          25000
`define FCI_ST0_SEEK_END     8'h20
`define FCI_ST0_INVALID      8'h80
`define FCI_ST3_TRACK0       8'h10
`define FCI_ST3_READY        8'h20
`define FCI_ADDR_DATA        4'h0
`define FCI_ADDR_STATUS      4'h1
`define FCI_ADDR_IRQ_STAT    4'h2
`define FCI_ADDR_IRQ_MASK    4'h3
`define FCI_ADDR_SPEC        4'h4
`define FCI_ADDR_SCAN_CFG    4'h5
`define FCI_ADDR_CYL0        4'h8
`define FCI_IRQ_DONE         0
`define FCI_IRQ_BAD          1
`define FCI_IRQ_RESULT       2
`endif

// *** hw/fci_pkg.sv ***
// Types for the command interpreter.
// Assumes fci_map.svh for numeric constants.
`default_nettype none
package fci_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_CMD, S_EXEC_STEP, S_EXEC_SCAN, S_RESULT
  } fci_phase_type;

  typedef enum logic [2:0] {
    C_NONE, C_SCAN, C_RECAL, C_SENSE_INT, C_SPECIFY, C_SEEK, C_SENSE_DRV, C_BAD
  } fci_cmd_type;

  typedef struct packed {
    fci_phase_type phase;
    fci_cmd_type   cmd;
    logic [3:0]    cnt;
    logic [3:0]    len;
    logic [7:0]    opcode;
    logic [1:0]    unit;
    logic          head;
    logic [7:0]    cyl_arg;
    logic [7:0]    sec;
    logic [7:0]    size_code;
    logic [7:0]    final_sec;
    logic [7:0]    gap3;
    logic [7:0]    stepf;
    logic [31:0]   cyl_all;
    logic [7:0]    spec_a;
    logic [7:0]    spec_b;
    logic [7:0]    st0;
    logic [7:0]    st1;
    logic [7:0]    st2;
    logic [7:0]    cmp_count;
    logic          cmp_mismatch;
    logic          int_pend;
    logic [15:0]   tick;
    logic [2:0]    irq_stat;
    logic [2:0]    irq_mask;
    logic [7:0]    rd_data;
    logic          irq;
    logic          step;
    logic          dir_in;
    logic [1:0]    drv_sel;
    logic [2:0]    t0_sync;
    logic          cmp_ready;
  } fci_state_type;
endpackage : fci_pkg
`default_nettype wire

// *** hw/fci_top.sv ***
// Command interpreter for the positioning and scan commands of a disk controller.
// Assumes a host on a simple strobe register port and one drive with step pins.
// Summary of operation
// - High-or-equal scan is nine bytes, opcode low bits 11101, flags on top.
// - Scan byte nine is step factor: one contiguous, two alternate sectors.
// - During scan, host-supplied bytes are compared against drive bytes.
// - Scan returns seven results: three status, cylinder, head, sector, count.
// - Head/unit byte: bit 2 head, bits 1-0 unit, bits 7-3 ignored.
// - Recalibrate is two bytes: opcode 07h and unit byte.
// - Recalibrate steps head to track zero, no result bytes.
// - Interrupt status query 08h returns status zero then present cylinder; here both bytes are returned.
// - Timing setup 03h byte two: step interval high, unload time low; here the byte is only stored, and steps follow STEP_CYCLES.
// - Timing setup byte three: load time bits 7-1, non-DMA bit 0.
// - Seek is three bytes: 0Fh, head/unit byte, target cylinder.
// - Seek moves head to target cylinder, no result bytes.
// - Drive status query is 04h then unit byte.
// - Drive status query returns one byte, drive status.
// - Unknown opcodes return status zero with top bit set.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "fci_map.svh"

module fci_top #(
  parameter int STEP_CYCLES = `FCI_SPEC_RATE_MS * `FCI_CLK_KHZ  // Cycles between step pulses
) (
  input  wire logic       CLK_SYS,      // System clock 25 MHz
  input  wire logic       RST_B,        // Synchronous reset, low
  input  wire logic [3:0] ADDR,         // Register address
  input  wire logic [7:0] WDATA,        // Write data
  input  wire logic       WR,           // Write strobe
  input  wire logic       RD,           // Read strobe
  input  wire logic [7:0] DISK_BYTE,    // Byte read from drive during scan
  input  wire logic       DISK_VALID,   // Drive byte strobe, same clock
  input  wire logic       TRACK0_PIN,   // Track zero from drive, async
  output logic      [7:0] RDATA,        // Read data, one cycle after RD
  output logic            IRQ,          // Level interrupt
  output logic            STEP,         // Head step pulse
  output logic            DIR_IN,       // Step direction, high toward centre
  output logic      [1:0] DRIVE_SEL,    // Selected unit
  output logic            CMP_READY     // Ready for a host compare byte
);
  fci_pkg::fci_state_type r, n;

  logic [7:0] status_word;
  logic [7:0] cur_cyl;
  logic       t0_level;
  logic       hit;

  // Present cylinder of the selected unit
  assign cur_cyl = r.cyl_all[r.unit*8 +: 8];
  // Second and third sync stages must both be high
  assign t0_level = r.t0_sync[2] & r.t0_sync[1];
  assign status_word = {r.phase == fci_pkg::S_RESULT, r.phase == fci_pkg::S_IDLE,
                        r.phase == fci_pkg::S_CMD, r.int_pend, r.len};

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  always_comb begin
    n = r;
    hit = 1'b0;
    n.step = 1'b0;
    n.rd_data = 8'h00;
    n.t0_sync = {r.t0_sync[1:0], TRACK0_PIN};

    // Register reads; data register read pops a result byte
    if (RD) begin
      case (ADDR)
        `FCI_ADDR_DATA: begin
          if (r.phase == fci_pkg::S_RESULT) begin
            case (r.cmd)
              fci_pkg::C_SCAN: begin
                case (r.cnt)
                  4'h0: n.rd_data = r.st0;
                  4'h1: n.rd_data = r.st1;
                  4'h2: n.rd_data = r.st2;
                  4'h3: n.rd_data = r.cyl_arg;
                  4'h4: n.rd_data = {7'h00, r.head};
                  4'h5: n.rd_data = r.sec;
                  default: n.rd_data = r.cmp_count;
                endcase
              end
              fci_pkg::C_SENSE_INT: n.rd_data = (r.cnt == 4'h0) ? r.st0 : cur_cyl;
              fci_pkg::C_SENSE_DRV: begin
                n.rd_data = `FCI_ST3_READY | {5'h00, r.head, r.unit};
                if (t0_level) n.rd_data = n.rd_data | `FCI_ST3_TRACK0;
              end
              default: n.rd_data = `FCI_ST0_INVALID;
            endcase
            n.cnt = r.cnt + 4'h1;
            // idle only after last result read
            if (r.cnt + 4'h1 == r.len) begin
              n.phase = fci_pkg::S_IDLE;
              n.cnt = 4'h0;
            end
          end
        end
        `FCI_ADDR_STATUS:   n.rd_data = status_word;
        `FCI_ADDR_IRQ_STAT: n.rd_data = {5'h00, r.irq_stat};
        `FCI_ADDR_IRQ_MASK: n.rd_data = {5'h00, r.irq_mask};
        `FCI_ADDR_SPEC:     n.rd_data = r.spec_a;
        `FCI_ADDR_SCAN_CFG: n.rd_data = r.spec_b;
        default: begin
          if (ADDR[3:2] == 2'b10) n.rd_data = r.cyl_all[ADDR[1:0]*8 +: 8];
        end
      endcase
    end

    // Interrupt register writes: status clears by writing one, mask is written directly
    if (WR && ADDR == `FCI_ADDR_IRQ_STAT) n.irq_stat = r.irq_stat & ~WDATA[2:0];
    if (WR && ADDR == `FCI_ADDR_IRQ_MASK) n.irq_mask = WDATA[2:0];

    // Command bytes accepted only while idle or collecting
    if (WR && ADDR == `FCI_ADDR_DATA &&
        (r.phase == fci_pkg::S_IDLE || r.phase == fci_pkg::S_CMD)) begin
      if (r.phase == fci_pkg::S_IDLE) begin
        n.opcode = WDATA;
        n.cnt = 4'h1;
        n.phase = fci_pkg::S_CMD;
        n.len = `FCI_LEN_SENSE_INT;
        if (WDATA[4:0] == `FCI_OP_LOW_SCAN_HE) begin
          n.cmd = fci_pkg::C_SCAN; n.len = `FCI_LEN_SCAN;
        end else if (WDATA == `FCI_OP_RECAL) begin
          n.cmd = fci_pkg::C_RECAL; n.len = `FCI_LEN_RECAL;
        end else if (WDATA == `FCI_OP_SPECIFY) begin
          n.cmd = fci_pkg::C_SPECIFY; n.len = `FCI_LEN_SPECIFY;
        end else if (WDATA == `FCI_OP_SEEK) begin
          n.cmd = fci_pkg::C_SEEK; n.len = `FCI_LEN_SEEK;
        end else if (WDATA == `FCI_OP_SENSE_DRV) begin
          n.cmd = fci_pkg::C_SENSE_DRV; n.len = `FCI_LEN_SENSE_DRV;
        end else if (WDATA == `FCI_OP_SENSE_INT) begin
          n.cmd = fci_pkg::C_SENSE_INT;
          n.phase = fci_pkg::S_RESULT; n.cnt = 4'h0; n.len = `FCI_RES_SENSE_INT;
          n.st0 = r.int_pend ? (`FCI_ST0_SEEK_END | {6'h00, r.unit}) : `FCI_ST0_INVALID;
          n.int_pend = 1'b0;
          n.irq_stat[`FCI_IRQ_DONE] = 1'b0;
        end else begin
          n.cmd = fci_pkg::C_BAD;
          n.phase = fci_pkg::S_RESULT; n.cnt = 4'h0; n.len = `FCI_RES_INVALID;
          n.st0 = `FCI_ST0_INVALID;
          hit = 1'b1;
        end
      end else begin
        // head bit 2, unit bits 1-0, rest ignored
        if (r.cnt == 4'h1 && r.cmd != fci_pkg::C_SPECIFY) begin
          n.unit = WDATA[1:0];
          n.head = WDATA[`FCI_BIT_HD];
        end
        case (r.cmd)
          fci_pkg::C_SCAN: begin
            case (r.cnt)
              4'h2: n.cyl_arg = WDATA;
              4'h4: n.sec = WDATA;
              4'h5: n.size_code = WDATA;
              4'h6: n.final_sec = WDATA;
              4'h7: n.gap3 = WDATA;
              4'h8: n.stepf = WDATA;
              default: ;
            endcase
          end
          fci_pkg::C_SPECIFY: begin
            if (r.cnt == 4'h1) n.spec_a = WDATA;
            else n.spec_b = WDATA;
          end
          fci_pkg::C_SEEK: if (r.cnt == 4'h2) n.cyl_arg = WDATA;
          default: ;
        endcase
        n.cnt = r.cnt + 4'h1;
        if (r.cnt + 4'h1 == r.len) begin
          n.cnt = 4'h0;
          n.tick = 16'h0000;
          case (r.cmd)
            fci_pkg::C_SCAN: begin
              n.phase = fci_pkg::S_EXEC_SCAN;
              n.cmp_count = 8'h00;
              n.cmp_mismatch = 1'b0;
            end
            fci_pkg::C_RECAL: begin
              n.cyl_arg = 8'h00;
              n.phase = fci_pkg::S_EXEC_STEP;
            end
            fci_pkg::C_SEEK: n.phase = fci_pkg::S_EXEC_STEP;
            fci_pkg::C_SENSE_DRV: begin
              n.phase = fci_pkg::S_RESULT; n.len = `FCI_RES_SENSE_DRV;
            end
            default: n.phase = fci_pkg::S_IDLE;
          endcase
        end
      end
    end

    // Head stepping, one pulse per STEP_CYCLES
    if (r.phase == fci_pkg::S_EXEC_STEP) begin
      n.tick = r.tick + 16'h0001;
      n.dir_in = (r.cyl_arg > cur_cyl);
      if (r.tick == 16'(STEP_CYCLES - 1)) begin
        n.tick = 16'h0000;
        // recalibrate ends on track zero input
        if ((r.cmd == fci_pkg::C_RECAL) ? t0_level : (r.cyl_arg == cur_cyl)) begin
          if (r.cmd == fci_pkg::C_RECAL) n.cyl_all[r.unit*8 +: 8] = 8'h00;
          n.phase = fci_pkg::S_IDLE;
          n.int_pend = 1'b1;
          hit = 1'b1;
        end else begin
          n.step = 1'b1;
          if (r.cmd != fci_pkg::C_RECAL)
            n.cyl_all[r.unit*8 +: 8] = (r.cyl_arg > cur_cyl) ? cur_cyl + 8'h01 : cur_cyl - 8'h01;
        end
      end
    end

    // compare host bytes with drive bytes
    if (r.phase == fci_pkg::S_EXEC_SCAN && DISK_VALID && WR && ADDR == `FCI_ADDR_DATA) begin
      n.cmp_count = r.cmp_count + 8'h01;
      if (DISK_BYTE < WDATA) n.cmp_mismatch = 1'b1;
      if (r.cmp_count == r.size_code - 8'h01) begin
        n.phase = fci_pkg::S_RESULT;
        n.len = `FCI_RES_SCAN;
        n.st0 = {5'h00, r.head, r.unit};
        n.st1 = 8'h00;
        n.st2 = {5'h00, ~(r.cmp_mismatch | (DISK_BYTE < WDATA)), 2'b00};
        n.sec = r.sec + ((r.stepf == `FCI_STEP_ALT) ? 8'h02 : 8'h01);
      end
    end

    // Interrupt status: set wins over clear
    // Decoded command of this cycle, not the previous one
    if (hit && n.cmd == fci_pkg::C_BAD) n.irq_stat[`FCI_IRQ_BAD] = 1'b1;
    if (hit && n.cmd != fci_pkg::C_BAD) n.irq_stat[`FCI_IRQ_DONE] = 1'b1;
    if (n.phase == fci_pkg::S_RESULT && r.phase != fci_pkg::S_RESULT)
      n.irq_stat[`FCI_IRQ_RESULT] = 1'b1;
    n.irq = |(n.irq_stat & n.irq_mask);
    n.drv_sel = n.unit;
    // Compare window flag drops with the phase, not a cycle later
    n.cmp_ready = (n.phase == fci_pkg::S_EXEC_SCAN);
  end

  //--------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from flops
  assign RDATA = r.rd_data;
  assign IRQ = r.irq;
  assign STEP = r.step;
  assign DIR_IN = r.dir_in;
  assign DRIVE_SEL = r.drv_sel;
  assign CMP_READY = r.cmp_ready;
endmodule : fci_top
`default_nettype wire

// *** bench/fci_drive_model.sv ***
// Behavioural drive: head position, track-zero sense, disk data bytes.
// Assumes step pulses one system clock long and the bench strobing valid.
`timescale 1ns/10ps
`default_nettype none
module fci_drive_model (
  input  wire logic       clk,        // System clock
  input  wire logic       step,       // Head step pulse
  input  wire logic       dir_in,     // High toward centre
  input  wire logic       valid,      // Disk byte consumed
  output var  logic       track0,     // High at cylinder zero
  output var  logic [7:0] disk_byte,  // Byte under the head
  output var  int         cyl         // Head position
);
  // Head starts off track zero so recalibrate must really step
  initial begin
    cyl = 3;
    disk_byte = 8'h90;
  end
  // head follows pulses, outer stop at zero
  always @(posedge clk) begin
    if (step && dir_in) begin
      cyl <= cyl + 1;
    end else if (step && cyl > 0) begin
      cyl <= cyl - 1;
    end
  end
  assign track0 = (cyl == 0);
  always @(posedge clk) begin
    if (valid) begin
      disk_byte <= disk_byte + 8'h13;
    end
  end
endmodule : fci_drive_model
`default_nettype wire

// *** bench/fci_top_assertions.sv ***
// Port checker for the command interpreter.
// Assumes STEP_CYCLES of four or more and bench write-gap-read spacing.
`timescale 1ns/10ps
`default_nettype none
module fci_top_assertions #(
  parameter int STEP_CYCLES = 25000   // Cycles between step pulses
) (
  input wire logic       CLK_SYS,     // System clock
  input wire logic       RST_B,       // Reset, low
  input wire logic [3:0] ADDR,        // Address
  input wire logic [7:0] WDATA,       // Write data
  input wire logic       WR,          // Write strobe
  input wire logic       RD,          // Read strobe
  input wire logic [7:0] DISK_BYTE,   // Drive byte
  input wire logic       DISK_VALID,  // Drive byte strobe
  input wire logic       TRACK0_PIN,  // Track zero
  input wire logic [7:0] RDATA,       // Read data
  input wire logic       IRQ,         // Interrupt
  input wire logic       STEP,        // Step pulse
  input wire logic       DIR_IN,      // Direction
  input wire logic [1:0] DRIVE_SEL,   // Unit
  input wire logic       CMP_READY    // Compare ready
);
  logic cmd_wr;
  assign cmd_wr = WR && ADDR == 4'h0;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // Opcode write, idle gap, then the result read
  sequence s_bad_op;
    cmd_wr && WDATA == 8'hff ##2 RD && ADDR == 4'h0;
  endsequence
  sequence s_pulse_end;
    STEP ##1 !STEP;
  endsequence
  property p_rdata_quiet;
    !RD |=> RDATA == 8'h00;
  endproperty
  property p_bad_op;
    s_bad_op |=> RDATA[7];
  endproperty
  property p_step_pulse;
    STEP |=> !STEP;
  endproperty
  property p_step_gap;
    s_pulse_end |-> !STEP[*2];
  endproperty
  property p_irq_mask_off;
    WR && ADDR == 4'h3 && WDATA == 8'h00 |-> ##2 !IRQ;
  endproperty
  // Sync delay absorbed by six samples at track zero
  property p_track0_stop;
    (TRACK0_PIN && !DIR_IN)[*6] |-> !STEP;
  endproperty
  property p_sel_cause;
    !$stable(DRIVE_SEL) |-> $past(cmd_wr) || $past(cmd_wr, 2);
  endproperty
  property p_cmp_cause;
    $rose(CMP_READY) |-> $past(cmd_wr) || $past(cmd_wr, 2);
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside slot");
  a_bad_op: assert property (p_bad_op) else $error("invalid flag missing");
  a_step_pulse: assert property (p_step_pulse) else $error("step too long");
  a_step_gap: assert property (p_step_gap) else $error("steps too close");
  a_irq_mask_off: assert property (p_irq_mask_off) else $error("masked irq high");
  a_track0_stop: assert property (p_track0_stop) else $error("step past zero");
  a_sel_cause: assert property (p_sel_cause) else $error("unit changed alone");
  a_cmp_cause: assert property (p_cmp_cause) else $error("compare without cmd");
endmodule : fci_top_assertions
`default_nettype wire

// *** bench/fci_top_tb_top.sv ***
// Self-checking bench for the command interpreter with a drive model.
// Assumes a 25 MHz clock and a step interval shortened to four cycles.
`timescale 1ns/10ps
`default_nettype none
`include "fci_map.svh"
module fci_top_tb_top;
  localparam int STEPS = 4;  // Short step interval keeps seeks brief
  logic       CLK_SYS = 1'b0;
  logic       RST_B = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic       DISK_VALID = 1'b0;
  logic [7:0] RDATA, DISK_BYTE, d, u, c, h;
  logic       IRQ, STEP, DIR_IN, CMP_READY, TRACK0_PIN;
  logic [1:0] DRIVE_SEL;
  logic [7:0] args [9];
  logic [7:0] res [7];
  int         num_errors = 0;
  int         comparisons = 0;
  int         cycles = 0;
  int         cyl;
  int         p0;
  logic [7:0] pc [4] = '{default: 8'h00};
  always #20 CLK_SYS = ~CLK_SYS;
  fci_top #(.STEP_CYCLES(STEPS)) dut (.CLK_SYS, .RST_B, .ADDR, .WDATA, .WR, .RD, .DISK_BYTE,
    .DISK_VALID, .TRACK0_PIN, .RDATA, .IRQ, .STEP, .DIR_IN, .DRIVE_SEL, .CMP_READY);
  fci_drive_model drive (.clk(CLK_SYS), .step(STEP), .dir_in(DIR_IN), .valid(DISK_VALID),
    .track0(TRACK0_PIN), .disk_byte(DISK_BYTE), .cyl(cyl));
  // Cylinder register address of a unit
  function automatic logic [3:0] cyl_addr(input logic [7:0] ub);
    return 4'h8 + {2'h0, ub[1:0]};
  endfunction : cyl_addr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK_SYS);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge CLK_SYS);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    @(negedge CLK_SYS);
    v = RDATA;
  endtask : rd
  // Bounded wait on the interrupt or the compare window
  task automatic wait_hi(input bit on_irq);
    @(negedge CLK_SYS);
    for (int n = 0; n < 3000 && (on_irq ? IRQ : CMP_READY) !== 1'b1; n++) begin
      @(negedge CLK_SYS);
    end
    chk({7'h0, on_irq ? IRQ : CMP_READY}, 8'h01);
  endtask : wait_hi
  task automatic wait_result;
    d = 8'h00;
    for (int n = 0; n < 20 && d[7] !== 1'b1; n++) begin
      rd(4'h1, d);
    end
  endtask : wait_result
  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'h5e37));
    repeat (8) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    wr(4'h0, 8'hff);
    rd(4'h0, d);
    chk(d & `FCI_ST0_INVALID, `FCI_ST0_INVALID);
    rd(4'h2, d);
    chk(d & 8'h03, 8'h02);
    u = 8'($urandom);
    c = 8'($urandom);
    wr(4'h0, `FCI_OP_SPECIFY);
    wr(4'h0, u);
    wr(4'h0, c);
    rd(4'h4, d);
    chk(d, u);
    rd(4'h5, d);
    chk(d, c);
    wr(4'h2, 8'h07);
    wr(4'h3, 8'h07);
    // Three seeks to random units and cylinders, junk in the ignored unit bits
    for (int i = 0; i < 3; i++) begin
      u = 8'($urandom);
      c = 8'($urandom_range(76, 1));
      p0 = cyl;
      wr(4'h0, `FCI_OP_SEEK);
      wr(4'h0, u);
      wr(4'h0, c);
      wait_hi(1'b1);
      chk(8'(cyl - p0), c - pc[u[1:0]]);
      pc[u[1:0]] = c;
      chk({6'h0, DRIVE_SEL}, {6'h0, u[1:0]});
      rd(cyl_addr(u), d);
      chk(d, c);
      wr(4'h3, 8'h00);
      repeat (2) @(negedge CLK_SYS);
      chk({7'h0, IRQ}, 8'h00);
      wr(4'h3, 8'h07);
      repeat (2) @(negedge CLK_SYS);
      chk({7'h0, IRQ}, 8'h01);
      wr(4'h0, `FCI_OP_SENSE_INT);
      rd(4'h0, d);
      chk(d & `FCI_ST0_SEEK_END, `FCI_ST0_SEEK_END);
      rd(4'h0, d);
      chk(d, c);
      rd(4'h2, d);
      chk(d & 8'h01, 8'h00);
      wr(4'h2, 8'h07);
      repeat (2) @(negedge CLK_SYS);
      chk({7'h0, IRQ}, 8'h00);
    end
    u = 8'($urandom) & 8'hfb;
    wr(4'h0, `FCI_OP_RECAL);
    wr(4'h0, u);
    wait_hi(1'b1);
    chk(8'(cyl), 8'h00);
    rd(cyl_addr(u), d);
    chk(d, 8'h00);
    wr(4'h0, `FCI_OP_SENSE_DRV);
    wr(4'h0, u);
    wait_result;
    rd(4'h0, d);
    chk(d & `FCI_ST3_TRACK0, `FCI_ST3_TRACK0);
    rd(4'h1, d);
    chk(d & 8'h80, 8'h00);
    // Scan of three bytes, host never above disk
    u = 8'($urandom);
    c = 8'($urandom_range(76, 0));
    h = {7'h0, u[2]};
    args = '{{u[7:5], 5'h1d}, u, c, h, 8'h01, 8'h03, 8'h09, 8'h1b, 8'h01 + {7'h0, u[3]}};
    foreach (args[k]) wr(4'h0, args[k]);
    wait_hi(1'b0);
    repeat (3) begin
      @(posedge CLK_SYS);
      WR <= 1'b1;
      ADDR <= 4'h0;
      DISK_VALID <= 1'b1;
      WDATA <= DISK_BYTE - 8'($urandom_range(5, 0));
      @(posedge CLK_SYS);
      WR <= 1'b0;
      DISK_VALID <= 1'b0;
    end
    wait_result;
    foreach (res[k]) rd(4'h0, res[k]);
    chk(res[2] & 8'h04, 8'h04);
    chk(res[3], c);
    chk(res[4], h);
    chk(res[6], 8'h03);
    chk(res[5], 8'h02 + {7'h0, u[3]});
    rd(4'h1, d);
    chk(d & 8'h80, 8'h00);
    tally_and_finish;
  end
endmodule : fci_top_tb_top
bind fci_top fci_top_assertions #(.STEP_CYCLES(STEP_CYCLES)) chk_i (.CLK_SYS, .RST_B, .ADDR,
  .WDATA, .WR, .RD, .DISK_BYTE, .DISK_VALID, .TRACK0_PIN, .RDATA, .IRQ, .STEP, .DIR_IN,
  .DRIVE_SEL, .CMP_READY);
`default_nettype wire
